// ===== verilog/vcx_defines.vh
// Constants for the video crosspoint configuration port
`ifndef VCX_DEFINES_VH
`define VCX_DEFINES_VH

// ----------------------------------------------------------------
// Bus address
// ----------------------------------------------------------------
`define VCX_ADDR_LOW_BITS 6'h06
`define VCX_ADDR_STRAP_HI_POS 7
`define VCX_ADDR_STRAP_LO_POS 6

// ----------------------------------------------------------------
// Internal register offsets
// ----------------------------------------------------------------
`define VCX_OFS_ROUTE_ONE_TWO 8'h00
`define VCX_OFS_ROUTE_THREE_FOUR 8'h01
`define VCX_OFS_ROUTE_FIVE_SIX 8'h02
`define VCX_OFS_INPUT_COND 8'h03
`define VCX_OFS_GAIN_SELECT 8'h04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define VCX_ROUTE_ODD_LSB 0
`define VCX_ROUTE_ODD_MSB 3
`define VCX_ROUTE_EVEN_LSB 4
`define VCX_ROUTE_EVEN_MSB 7
`define VCX_GAIN_MSB 5
`define VCX_GAIN_LSB 0

// ----------------------------------------------------------------
// Source codes and reset values
// ----------------------------------------------------------------
`define VCX_SRC_OFF 4'h0
`define VCX_SRC_FIRST 4'h1
`define VCX_SRC_LAST 4'h8
`define VCX_RST_ROUTE 8'h00
`define VCX_RST_COND 8'h00
`define VCX_RST_GAIN 6'h00

// ----------------------------------------------------------------
// Byte framing
// ----------------------------------------------------------------
`define VCX_BITS_PER_BYTE 4'h8

`endif

// ===== verilog/vcx_config.v
// Serial configuration port and register bank of the 8x6 video crosspoint
// Notes on behaviour
// - Answer address byte whose low six bits are 000110; straps give top two bits.
// - Routing register bits 3:0 feed odd output, bits 7:4 following even output.
// - Source code 0000 is off; codes 0001 to 1000 pick inputs one to eight.
// - Several outputs may select the same input at once.
// - Routing registers at 0x00, 0x01, 0x02 for output pairs one-two, three-four, five-six.
// - Register 0x03 has one bit per input; one clamps, zero biases.
// - Register 0x04 bits 5:0 give output gain; zero is 6dB, one 0dB.
// - Reset clears all routing, conditioning and gain bits.
// - Writes to other addresses are acknowledged but change nothing.
// - Off code disables the output amplifier, leaving the output high impedance.
// - Configuration registers are write-only; nothing reads back.
// - Conditioning bits live apart from routing, so routing writes leave them alone.
// - Addressed device acknowledges during the ninth clock after every received byte.
// - Any number of bytes may pass between start and stop.
`timescale 1ns/1ns
`default_nettype none
`include "vcx_defines.vh"

module vcx_config (
    input wire MCLK,
    input wire RST_N,
    input wire SCL_IN,
    input wire SDA_IN,
    output wire SDA_OUT,
    output reg SDA_OE,
    input wire SLAVE_ADDRESS_STRAP_LOW,
    input wire SLAVE_ADDRESS_STRAP_HIGH,
    output reg [47:0] ROUTE_SELECT,
    output reg [5:0] AMP_ENABLE,
    output reg [7:0] CLAMP_MODE,
    output reg [5:0] GAIN_ZERO_DB
);

    // ----------------------------------------------------------------
    // States of the byte receiver
    // ----------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_ADDR = 2'b01;
    localparam ST_REG = 2'b10;
    localparam ST_DATA = 2'b11;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    reg rst_meta;
    reg rst_n;

    always @(posedge MCLK or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // Pin synchronisers
    // ----------------------------------------------------------------
    // First stage feeds only the second; edges come from stages two and three
    reg [3:0] pin_meta;
    reg [3:0] pin_sync;
    reg scl_prev;
    reg sda_prev;
    wire scl = pin_sync[0];
    wire sda = pin_sync[1];
    wire strap_low = pin_sync[2];
    wire strap_high = pin_sync[3];

    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            pin_meta <= 4'hF;
            pin_sync <= 4'hF;
            scl_prev <= 1'b1;
            sda_prev <= 1'b1;
        end else begin
            pin_meta <= {SLAVE_ADDRESS_STRAP_HIGH, SLAVE_ADDRESS_STRAP_LOW, SDA_IN, SCL_IN};
            pin_sync <= pin_meta;
            scl_prev <= pin_sync[0];
            sda_prev <= pin_sync[1];
        end
    end

    wire scl_rise = scl & ~scl_prev;
    wire scl_fall = ~scl & scl_prev;
    wire bus_start = scl & scl_prev & sda_prev & ~sda;
    wire bus_stop = scl & scl_prev & ~sda_prev & sda;

    // ----------------------------------------------------------------
    // Source decode
    // ----------------------------------------------------------------
    // code to one-hot input
    function [7:0] src_onehot;
        input [3:0] code;
        begin
            if (code >= `VCX_SRC_FIRST && code <= `VCX_SRC_LAST) begin
                src_onehot = 8'h01 << (code - `VCX_SRC_FIRST);
            end else begin
                src_onehot = 8'h00;
            end
        end
    endfunction

    // ----------------------------------------------------------------
    // Byte receiver
    // ----------------------------------------------------------------
    reg [1:0] state;
    reg [3:0] bit_cnt;
    reg [7:0] shift;
    reg in_ack;
    reg [7:0] reg_ptr;
    reg [7:0] route_reg [0:2];
    reg [7:0] cond_reg;
    reg [5:0] gain_reg;

    wire [7:0] own_address = {strap_high, strap_low, `VCX_ADDR_LOW_BITS};
    wire byte_done = scl_fall && !in_ack && bit_cnt == `VCX_BITS_PER_BYTE;

    // Open drain: only ever pulls low
    assign SDA_OUT = 1'b0;

    // ----------------------------------------------------------------
    // Register write decode
    // ----------------------------------------------------------------
    // Strobes qualify the pointer only; the receiver adds the byte timing
    reg wr_route_one_two;
    reg wr_route_three_four;
    reg wr_route_five_six;
    reg wr_input_cond;
    reg wr_gain_select;

    always @* begin
        wr_route_one_two = 1'b0;
        wr_route_three_four = 1'b0;
        wr_route_five_six = 1'b0;
        wr_input_cond = 1'b0;
        wr_gain_select = 1'b0;
        // routing pairs at 0x00 to 0x02
        if (reg_ptr == `VCX_OFS_ROUTE_ONE_TWO) begin
            wr_route_one_two = 1'b1;
        end else if (reg_ptr == `VCX_OFS_ROUTE_THREE_FOUR) begin
            wr_route_three_four = 1'b1;
        end else if (reg_ptr == `VCX_OFS_ROUTE_FIVE_SIX) begin
            wr_route_five_six = 1'b1;
        // own strobe, never shared with routing
        end else if (reg_ptr == `VCX_OFS_INPUT_COND) begin
            wr_input_cond = 1'b1;
        end else if (reg_ptr == `VCX_OFS_GAIN_SELECT) begin
            wr_gain_select = 1'b1;
        end
        // any other pointer raises no strobe
    end

    // ----------------------------------------------------------------
    // Receiver sequencing
    // ----------------------------------------------------------------
    // No clock stretching: the master must keep each bus phase four clocks long
    // Pointer wraps after 0xFF back to 0x00, the routing register for outputs one-two

    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            shift <= 8'h00;
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
            reg_ptr <= 8'h00;
            route_reg[0] <= `VCX_RST_ROUTE;
            route_reg[1] <= `VCX_RST_ROUTE;
            route_reg[2] <= `VCX_RST_ROUTE;
            cond_reg <= `VCX_RST_COND;
            gain_reg <= `VCX_RST_GAIN;
        end else if (bus_start) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (bus_stop) begin
            state <= ST_IDLE;
            bit_cnt <= 4'h0;
            in_ack <= 1'b0;
            SDA_OE <= 1'b0;
        end else if (state != ST_IDLE) begin
            if (scl_rise && bit_cnt < `VCX_BITS_PER_BYTE) begin
                shift <= {shift[6:0], sda};
                bit_cnt <= bit_cnt + 4'h1;
            end else if (byte_done) begin
                in_ack <= 1'b1;
                case (state)
                    ST_ADDR: begin
                        if (shift == own_address) begin
                            SDA_OE <= 1'b1;
                            state <= ST_REG;
                        end else begin
                            state <= ST_IDLE;
                        end
                    end
                    ST_REG: begin
                        reg_ptr <= shift;
                        SDA_OE <= 1'b1;
                        state <= ST_DATA;
                    end
                    default: begin
                        SDA_OE <= 1'b1;
                        // pointer steps so longer bursts keep writing
                        reg_ptr <= reg_ptr + 8'h01;
                        if (wr_route_one_two) begin
                            route_reg[0] <= shift;
                        end
                        if (wr_route_three_four) begin
                            route_reg[1] <= shift;
                        end
                        if (wr_route_five_six) begin
                            route_reg[2] <= shift;
                        end
                        if (wr_input_cond) begin
                            cond_reg <= shift;
                        end
                        // top two bits of the gain byte dropped
                        if (wr_gain_select) begin
                            gain_reg <= shift[`VCX_GAIN_MSB:`VCX_GAIN_LSB];
                        end
                    end
                endcase
            end else if (scl_fall && in_ack) begin
                // Release after the ninth clock
                in_ack <= 1'b0;
                SDA_OE <= 1'b0;
                bit_cnt <= 4'h0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Crosspoint controls
    // ----------------------------------------------------------------
    // settings only leave as control outputs, never back to the bus
    wire [47:0] next_route_select;
    wire [5:0] next_amp_enable;

    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : gen_out
            // low nibble odd output, high nibble next even output
            wire [3:0] code = (g % 2 == 0) ?
                route_reg[g / 2][`VCX_ROUTE_ODD_MSB:`VCX_ROUTE_ODD_LSB] :
                route_reg[g / 2][`VCX_ROUTE_EVEN_MSB:`VCX_ROUTE_EVEN_LSB];

            // each output decoded alone, so sharing an input is free
            assign next_route_select[g * 8 +: 8] = src_onehot(code);
            // off or unassigned code powers amplifier down
            assign next_amp_enable[g] = |next_route_select[g * 8 +: 8];
        end
    endgenerate

    // ----------------------------------------------------------------
    // Output register
    // ----------------------------------------------------------------
    // One stage so the analog switches never see decode glitches
    always @(posedge MCLK or negedge rst_n) begin
        if (!rst_n) begin
            ROUTE_SELECT <= 48'h000000000000;
            AMP_ENABLE <= 6'h00;
            CLAMP_MODE <= 8'h00;
            GAIN_ZERO_DB <= 6'h00;
        end else begin
            ROUTE_SELECT <= next_route_select;
            AMP_ENABLE <= next_amp_enable;
            CLAMP_MODE <= cond_reg;
            GAIN_ZERO_DB <= gain_reg;
        end
    end

endmodule

`default_nettype wire

// ===== verification/vcx_config_checker.sv
// Checker for the crosspoint configuration port
`timescale 1ns/1ns
`default_nettype none
module vcx_config_checker (
    input wire MCLK,
    input wire RST_N,
    input wire SDA_OUT,
    input wire SDA_OE,
    input wire [47:0] ROUTE_SELECT,
    input wire [5:0] AMP_ENABLE,
    input wire [7:0] CLAMP_MODE,
    input wire [5:0] GAIN_ZERO_DB
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RST_N);
    reset_clear_a: assert property ($rose(RST_N) |-> ROUTE_SELECT == 48'h0 && CLAMP_MODE == 8'h00)
        else $error("configuration not clear after reset");
    amp_one_a: assert property (AMP_ENABLE[0] == |ROUTE_SELECT[7:0])
        else $error("output one enable disagrees with its source");
    amp_six_a: assert property (AMP_ENABLE[5] == |ROUTE_SELECT[47:40])
        else $error("output six enable disagrees with its source");
    sel_one_a: assert property ($onehot0(ROUTE_SELECT[7:0]))
        else $error("output one selects several inputs");
    sel_six_a: assert property ($onehot0(ROUTE_SELECT[47:40]))
        else $error("output six selects several inputs");
    ack_hold_a: assert property ($rose(SDA_OE) |-> SDA_OE [*4])
        else $error("acknowledge dropped too early");
    ack_len_a: assert property ($rose(SDA_OE) |-> ##[4:16] !SDA_OE)
        else $error("acknowledge held too long");
    ack_low_a: assert property (SDA_OE |-> SDA_OUT == 1'b0)
        else $error("acknowledge drives a high level");
    cfg_write_a: assert property ($changed({ROUTE_SELECT, CLAMP_MODE, GAIN_ZERO_DB}) |-> ##[0:4] SDA_OE)
        else $error("configuration changed without an accepted byte");
    cover property ($rose(SDA_OE));
    cover property (CLAMP_MODE == 8'hA5);
    cover property (AMP_ENABLE == 6'h2F);
endmodule
bind vcx_config vcx_config_checker chk (.MCLK(MCLK), .RST_N(RST_N), .SDA_OUT(SDA_OUT), .SDA_OE(SDA_OE),
    .ROUTE_SELECT(ROUTE_SELECT), .AMP_ENABLE(AMP_ENABLE), .CLAMP_MODE(CLAMP_MODE), .GAIN_ZERO_DB(GAIN_ZERO_DB));
`default_nettype wire

// ===== verification/vcx_master.sv
// Bus master model for the configuration port
`timescale 1ns/1ns
`default_nettype none
module vcx_master (
    input wire logic clk,
    input wire logic sda_bus,
    output logic scl,
    output logic sda
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    // Quarter bus period; clock stands high between frames
    task q;
        repeat (2) @(posedge clk);
    endtask
    // address, register, then up to six data bytes (eight bytes in all)
    task send(input int n, input logic [63:0] d, output logic [7:0] ack);
        ack = 8'hFF;
        sda <= 1'b0;
        q;
        q;
        for (int i = 0; i < n; i++) begin
            for (int b = 7; b >= 0; b--) begin
                scl <= 1'b0;
                q;
                sda <= d[56 - 8 * i + b];
                q;
                scl <= 1'b1;
                q;
                q;
            end
            scl <= 1'b0;
            q;
            sda <= 1'b1;
            q;
            scl <= 1'b1;
            q;
            ack[i] = sda_bus;
            q;
        end
        scl <= 1'b0;
        q;
        sda <= 1'b0;
        q;
        scl <= 1'b1;
        q;
        sda <= 1'b1;
        q;
    endtask
endmodule
`default_nettype wire

// ===== verification/vcx_config_tb.sv
// Self-checking bench for the crosspoint configuration port
`timescale 1ns/1ns
`default_nettype none
module vcx_config_tb;
    logic mclk, rst_n, strap_lo, strap_hi;
    logic [7:0] ack;
    wire scl, sda_m, sda_oe, sda_out;
    wire [47:0] route;
    wire [5:0] amp, gain;
    wire [7:0] clamp;
    // Open drain with pull-up: low when either side pulls
    wire sda_bus = sda_m & ~(sda_oe & ~sda_out);
    int err_total = 0;
    int samples_checked = 0;
    vcx_master m (.clk(mclk), .sda_bus(sda_bus), .scl(scl), .sda(sda_m));
    vcx_config uut (.MCLK(mclk), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda_bus), .SDA_OUT(sda_out),
        .SDA_OE(sda_oe), .SLAVE_ADDRESS_STRAP_LOW(strap_lo), .SLAVE_ADDRESS_STRAP_HIGH(strap_hi),
        .ROUTE_SELECT(route), .AMP_ENABLE(amp), .CLAMP_MODE(clamp), .GAIN_ZERO_DB(gain));
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task check(input logic [71:0] seen, input logic [71:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task results;
        $display("compares %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task t_reset;
        check({route, clamp, amp, gain, sda_oe}, 72'h0);
    endtask
    // Burst runs past the last register into an unmapped one
    task t_burst;
        m.send(8, 64'h0600_1181_09A5_FF00, ack);
        check(ack, 8'h00);
        check(route, 48'h0000_8001_0101);
        check(amp, 6'h0F);
        check(clamp, 8'hA5);
        check(gain, 6'h3F);
    endtask
    task t_unmapped;
        m.send(3, {24'h0607FF, 40'h0}, ack);
        check(ack[2:0], 3'b000);
        check({route, clamp, gain}, {48'h0000_8001_0101, 8'hA5, 6'h3F});
    endtask
    task t_route_only;
        m.send(3, {24'h060210, 40'h0}, ack);
        check(route, 48'h0100_8001_0101);
        check(amp, 6'h2F);
        check(clamp, 8'hA5);
    endtask
    task t_strap;
        strap_hi <= 1'b1;
        repeat (8) @(posedge mclk);
        m.send(3, {24'h060300, 40'h0}, ack);
        check({ack[0], clamp}, {1'b1, 8'hA5});
        m.send(3, {24'h860300, 40'h0}, ack);
        check({ack[2:0], clamp}, {3'b000, 8'h00});
        strap_hi <= 1'b0;
        strap_lo <= 1'b1;
        repeat (8) @(posedge mclk);
        m.send(3, {24'h460305, 40'h0}, ack);
        check({ack[2:0], clamp}, {3'b000, 8'h05});
        strap_hi <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
    task t_midrun_reset;
        rst_n <= 1'b0;
        repeat (2) @(posedge mclk);
        check({route, clamp, amp, gain, sda_oe}, 72'h0);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        m.send(3, {24'hC60011, 40'h0}, ack);
        check({ack[2:0], route[7:0], amp[0]}, {3'b000, 8'h01, 1'b1});
    endtask
    initial begin
        rst_n = 1'b0;
        strap_lo = 1'b0;
        strap_hi = 1'b0;
        repeat (4) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (8) @(posedge mclk);
        t_reset;
        t_burst;
        t_unmapped;
        t_route_only;
        t_strap;
        t_midrun_reset;
        results;
    end
endmodule
`default_nettype wire
